// [rtl/tmps_defines.vh]
// register offsets, field positions and reset values of the temperature result registers
`ifndef TMPS_DEFINES_VH
`define TMPS_DEFINES_VH

// ---------------------------------------------------------------------------
// register indices (byte address on the bus is four times the index)
// ---------------------------------------------------------------------------
`define TMPS_IDX_LOCAL_TEMP   8'h00
`define TMPS_IDX_REMOTE_HI    8'h01
`define TMPS_IDX_LOCAL_LIMIT  8'h05
`define TMPS_IDX_REMOTE_LO    8'h10
`define TMPS_IDX_CONFIG       8'h45
`define TMPS_IDX_STATUS       8'h46

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define TMPS_RST_LOCAL_LIMIT  8'h46
`define TMPS_RST_CONFIG       8'h00
`define TMPS_RST_TEMP         8'h00

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define TMPS_CFG_EXT_BIT      0
`define TMPS_CFG_FILT_BIT     1
`define TMPS_CFG_MASK         8'h03
`define TMPS_STAT_CONV_BIT    0
`define TMPS_STAT_OVER_BIT    1
`define TMPS_LO_FRAC_MSB      7
`define TMPS_LO_FRAC_LSB      5
`define TMPS_LO_EXT_MSB       4
`define TMPS_LO_EXT_LSB       3

// ---------------------------------------------------------------------------
// remote reading limits, in 1/32 degree steps, 14-bit two's complement
// ---------------------------------------------------------------------------
`define TMPS_REMOTE_MAX_POS   14'h0FFF
// 127.875 degrees, the top of the eighth-degree range
`define TMPS_EXT_OVER_LIM     14'h0FFC
`define TMPS_REMOTE_MIN_NEG   14'h3000
`define TMPS_EXT_OVER_BITS    2'b11
`define TMPS_EXT_ZERO_BITS    2'b00

`endif

// [rtl/tmps_remote_fmt.v]
// formats one remote conversion into the signed high and low result bytes
`timescale 1ns/10ps
`include "tmps_defines.vh"

module tmps_remote_fmt (
  input  wire [13:0] raw_i,
  input  wire        ext_sel_i,
  input  wire        filt_on_i,
  output reg  [7:0]  hi_o,
  output reg  [7:0]  lo_o,
  output reg         over_o
);

  // -------------------------------------------------------------------------
  // saturation and low byte layout
  // -------------------------------------------------------------------------
  reg        pos_over;
  reg        neg_over;
  reg        ext_over;
  reg [12:0] sat;
  reg [1:0]  ext_bits;

  always @* begin
    // anything above 127.96875 cannot fit the signed byte pair
    pos_over = !raw_i[13] && (raw_i > `TMPS_REMOTE_MAX_POS);
    // above 127.875 the eighth-degree bytes alone no longer tell the truth
    ext_over = !raw_i[13] && (raw_i > `TMPS_EXT_OVER_LIM);
    neg_over = raw_i[13] && (raw_i < `TMPS_REMOTE_MIN_NEG);
    if (pos_over) begin
      sat = 13'h0FFF;
    end else if (neg_over) begin
      sat = 13'h1000;
    end else begin
      sat = raw_i[12:0];
    end
    if (filt_on_i && ext_sel_i) begin
      ext_bits = sat[1:0];
    end else if (ext_sel_i && ext_over) begin
      ext_bits = `TMPS_EXT_OVER_BITS;
    end else begin
      // filter on without extended resolution also reads 00
      ext_bits = `TMPS_EXT_ZERO_BITS;
    end
    hi_o   = sat[12:5];
    lo_o   = {sat[4:2], ext_bits, 3'b000};
    over_o = ext_over;
  end

endmodule

// [rtl/tmps_regs.v]
// temperature result and local setpoint register bank with an APB slave port
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "tmps_defines.vh"

module tmps_regs #(
  parameter ADDR_W = 12
) (
  input  wire              sys_clk_i,
  input  wire              nrst_i,
  // apb slave
  input  wire              psel_i,
  input  wire              penable_i,
  input  wire              pwrite_i,
  input  wire [ADDR_W-1:0] paddr_i,
  input  wire [31:0]       pwdata_i,
  input  wire [3:0]        pstrb_i,
  output wire [31:0]       prdata_o,
  output wire              pready_o,
  output wire              pslverr_o,
  // conversion results, same clock domain
  input  wire              conv_valid_i,
  input  wire [7:0]        local_temp_i,
  input  wire [13:0]       remote_raw_i,
  // values used by the rest of the sensor
  output wire [7:0]        local_high_limit_o,
  output wire              extended_range_select_o,
  output wire              filter_en_o
);

  // -------------------------------------------------------------------------
  // register selects
  // -------------------------------------------------------------------------
  localparam SEL_NONE   = 3'd0;
  localparam SEL_LOCAL  = 3'd1;
  localparam SEL_REM_HI = 3'd2;
  localparam SEL_LIMIT  = 3'd3;
  localparam SEL_REM_LO = 3'd4;
  localparam SEL_CONFIG = 3'd5;
  localparam SEL_STATUS = 3'd6;

  // word-aligned decode; a misaligned byte address maps to nothing
  function [2:0] reg_sel;
    input [ADDR_W-1:0] addr;
    reg   [ADDR_W-1:0] idx;
    begin
      idx = addr >> 2;
      if (addr[1:0] != 2'b00) begin
        reg_sel = SEL_NONE;
      end else begin
        case (idx)
          `TMPS_IDX_LOCAL_TEMP:  reg_sel = SEL_LOCAL;
          `TMPS_IDX_REMOTE_HI:   reg_sel = SEL_REM_HI;
          `TMPS_IDX_LOCAL_LIMIT: reg_sel = SEL_LIMIT;
          `TMPS_IDX_REMOTE_LO:   reg_sel = SEL_REM_LO;
          `TMPS_IDX_CONFIG:      reg_sel = SEL_CONFIG;
          `TMPS_IDX_STATUS:      reg_sel = SEL_STATUS;
          default:               reg_sel = SEL_NONE;
        endcase
      end
    end
  endfunction

  // a selected register that software may write
  function is_writable;
    input [2:0] sel;
    begin
      is_writable = (sel == SEL_LIMIT) || (sel == SEL_CONFIG);
    end
  endfunction

  // -------------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------------
  reg  [7:0]  local_temp_bits_r;
  reg  [7:0]  remote_signed_hi_r;
  reg  [7:0]  remote_signed_lo_r;
  reg  [7:0]  lo_shadow_r;
  reg  [7:0]  local_high_limit_bits_r;
  reg  [7:0]  cfg_r;
  reg         conv_seen_r;
  reg         remote_over_r;
  reg         pready_r;
  reg         pslverr_r;
  reg  [31:0] prdata_r;

  reg  [7:0]  limit_nxt;
  reg  [7:0]  cfg_nxt;
  reg  [7:0]  shadow_nxt;
  reg         conv_seen_nxt;
  reg  [31:0] rdata_nxt;
  reg         err_nxt;

  wire [2:0]  sel;
  wire        acc_pend;
  wire        acc_done;
  wire        wr_done;
  wire        rd_done;
  wire        ext_sel;
  wire        filt_on;
  wire [7:0]  fmt_hi;
  wire [7:0]  fmt_lo;
  wire        fmt_over;
  wire [7:0]  status_val;

  assign sel      = reg_sel(paddr_i);
  // one wait state: pready rises in the second access cycle
  assign acc_pend = psel_i && penable_i && !pready_r;
  assign acc_done = psel_i && penable_i && pready_r;
  assign wr_done  = acc_done && pwrite_i;
  assign rd_done  = acc_done && !pwrite_i;

  assign ext_sel  = cfg_r[`TMPS_CFG_EXT_BIT];
  assign filt_on  = cfg_r[`TMPS_CFG_FILT_BIT];

  assign status_val = {6'b00_0000, remote_over_r, conv_seen_r};

  // -------------------------------------------------------------------------
  // remote result formatting
  // -------------------------------------------------------------------------
  // the fraction layout is fixed at conversion time, so a later change of
  // the select bits only affects the next reading
  tmps_remote_fmt u_fmt (
    .raw_i     (remote_raw_i),
    .ext_sel_i (ext_sel),
    .filt_on_i (filt_on),
    .hi_o      (fmt_hi),
    .lo_o      (fmt_lo),
    .over_o    (fmt_over)
  );

  // -------------------------------------------------------------------------
  // writable registers, next values
  // -------------------------------------------------------------------------
  always @* begin
    limit_nxt = local_high_limit_bits_r;
    cfg_nxt   = cfg_r;
    if (wr_done && pstrb_i[0]) begin
      if (sel == SEL_LIMIT) begin
        limit_nxt = pwdata_i[7:0];
      end
      if (sel == SEL_CONFIG) begin
        cfg_nxt = pwdata_i[7:0] & `TMPS_CFG_MASK;
      end
    end
  end

  // -------------------------------------------------------------------------
  // shadow of the remote low byte
  // -------------------------------------------------------------------------
  // the shadow is loaded when the high byte read completes; the low byte
  // read then returns the fraction of that same conversion even if a new
  // result lands in between
  always @* begin
    shadow_nxt = lo_shadow_r;
    if (rd_done && (sel == SEL_REM_HI)) begin
      shadow_nxt = remote_signed_lo_r;
    end
  end

  // -------------------------------------------------------------------------
  // status flag: set by a conversion, cleared by reading the status word
  // -------------------------------------------------------------------------
  always @* begin
    conv_seen_nxt = conv_seen_r;
    if (rd_done && (sel == SEL_STATUS)) begin
      conv_seen_nxt = 1'b0;
    end
    // a conversion in the clearing cycle still sets the flag
    if (conv_valid_i) begin
      conv_seen_nxt = 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // read data and error answer
  // -------------------------------------------------------------------------
  always @* begin
    rdata_nxt = 32'h0000_0000;
    err_nxt   = 1'b0;
    case (sel)
      SEL_LOCAL: begin
        rdata_nxt[7:0] = local_temp_bits_r;
      end
      SEL_REM_HI: begin
        rdata_nxt[7:0] = remote_signed_hi_r;
      end
      SEL_LIMIT: begin
        rdata_nxt[7:0] = local_high_limit_bits_r;
      end
      SEL_REM_LO: begin
        rdata_nxt[7:0] = {lo_shadow_r[7:3], 3'b000};
      end
      SEL_CONFIG: begin
        rdata_nxt[7:0] = cfg_r;
      end
      SEL_STATUS: begin
        rdata_nxt[7:0] = status_val;
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
    // writes to the reading registers are dropped quietly, no error
    if (pwrite_i) begin
      rdata_nxt = 32'h0000_0000;
      if (sel != SEL_NONE && !is_writable(sel)) begin
        err_nxt = 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // bus handshake registers
  // -------------------------------------------------------------------------
  // ready is kept apart so its one-cycle pulse never waits on the decode
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= acc_pend;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (acc_pend) begin
      prdata_r <= rdata_nxt;
    end else begin
      prdata_r <= 32'h0000_0000;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pslverr_r <= 1'b0;
    end else if (acc_pend) begin
      pslverr_r <= err_nxt;
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // software registers, low byte shadow and conversion flag
  // -------------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      local_high_limit_bits_r <= `TMPS_RST_LOCAL_LIMIT;
    end else begin
      local_high_limit_bits_r <= limit_nxt;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r <= `TMPS_RST_CONFIG;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lo_shadow_r <= `TMPS_RST_TEMP;
    end else begin
      lo_shadow_r <= shadow_nxt;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_seen_r <= 1'b0;
    end else begin
      conv_seen_r <= conv_seen_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // conversion results
  // -------------------------------------------------------------------------
  // only a finished conversion writes these; the bus has no path to them
  // one process per result so a later consumer can tap any one of them
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      local_temp_bits_r <= `TMPS_RST_TEMP;
    end else if (conv_valid_i) begin
      local_temp_bits_r <= local_temp_i;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      remote_signed_hi_r <= `TMPS_RST_TEMP;
    end else if (conv_valid_i) begin
      remote_signed_hi_r <= fmt_hi;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      remote_signed_lo_r <= `TMPS_RST_TEMP;
    end else if (conv_valid_i) begin
      remote_signed_lo_r <= fmt_lo;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      remote_over_r <= 1'b0;
    end else if (conv_valid_i) begin
      remote_over_r <= fmt_over;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign prdata_o                = prdata_r;
  assign pready_o                = pready_r;
  assign pslverr_o               = pslverr_r;
  assign local_high_limit_o      = local_high_limit_bits_r;
  assign extended_range_select_o = cfg_r[`TMPS_CFG_EXT_BIT];
  assign filter_en_o             = cfg_r[`TMPS_CFG_FILT_BIT];

endmodule

// [sim/tmps_regs_sva.sv]
// assertion checker for the temperature result register bank
`timescale 1ns/10ps
module tmps_regs_chk #(
  parameter ADDR_W = 12
) (
  input wire              sys_clk_i,
  input wire              nrst_i,
  input wire              psel_i,
  input wire              penable_i,
  input wire              pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [31:0]       pwdata_i,
  input wire [3:0]        pstrb_i,
  input wire [31:0]       prdata_o,
  input wire              pready_o,
  input wire              pslverr_o,
  input wire              conv_valid_i,
  input wire [7:0]        local_temp_i,
  input wire [13:0]       remote_raw_i,
  input wire [7:0]        local_high_limit_o,
  input wire              extended_range_select_o,
  input wire              filter_en_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // lane 0 strobe gates every write
  wire wr_done = pready_o && pwrite_i && pstrb_i[0];
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_one_wait: assert property (psel_i && penable_i && !$past(penable_i) |=> pready_o)
    else $error("ready not in second access cycle");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i) else $error("ready outside access");
  a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0000_0000) else $error("read data not idle");
  a_err_map: assert property (pready_o |-> pslverr_o == !(paddr_i inside
    {12'h000, 12'h004, 12'h014, 12'h040, 12'h114, 12'h118})) else $error("error flag wrong");
  a_lo_zero_bits: assert property (pready_o && !pwrite_i && paddr_i == 12'h040 |-> prdata_o[2:0] == 3'h0)
    else $error("low byte bits 2:0 not zero");
  a_limit_write: assert property (wr_done && paddr_i == 12'h014 |=> local_high_limit_o == $past(pwdata_i[7:0]))
    else $error("limit write lost");
  a_limit_hold: assert property (!(wr_done && paddr_i == 12'h014) |=> $stable(local_high_limit_o))
    else $error("limit changed without write");
  a_ext_write: assert property (wr_done && paddr_i == 12'h114 |=> extended_range_select_o == $past(pwdata_i[0]))
    else $error("extension select not written");
  a_reset_limit: assert property ($rose(nrst_i) |-> local_high_limit_o == 8'h46)
    else $error("limit reset value wrong");
  c_lo_read: cover property (pready_o && !pwrite_i && paddr_i == 12'h040);
  c_limit_wr: cover property (wr_done && paddr_i == 12'h014);
  c_conv: cover property (conv_valid_i);
endmodule

bind tmps_regs tmps_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .conv_valid_i(conv_valid_i),
  .local_temp_i(local_temp_i), .remote_raw_i(remote_raw_i), .local_high_limit_o(local_high_limit_o),
  .extended_range_select_o(extended_range_select_o), .filter_en_o(filter_en_o));

// [sim/tmps_regs_bench.sv]
// self-checking bench for the temperature result register bank
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module tmps_regs_bench;
  logic        sys_clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, conv_valid_i = 0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0]  pstrb_i = 4'h1;
  logic [7:0]  local_temp_i = 8'h00;
  logic [13:0] remote_raw_i = 14'h0000;
  logic [31:0] prdata_o, q;
  logic [7:0]  local_high_limit_o;
  logic        pready_o, pslverr_o, extended_range_select_o, filter_en_o, e;
  logic [13:0] raws [2] = '{14'h0335, 14'h3FE3};
  int          n_errors = 0, samples_checked = 0, cycles = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  tmps_regs #(.ADDR_W(12)) u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .conv_valid_i(conv_valid_i), .local_temp_i(local_temp_i),
    .remote_raw_i(remote_raw_i), .local_high_limit_o(local_high_limit_o),
    .extended_range_select_o(extended_range_select_o), .filter_en_o(filter_en_o));
  // ---------------------------------------------------------------------------
  // bus and conversion drivers
  // ---------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= {24'h00_0000, d};
    @(posedge sys_clk_i);
    penable_i <= 1;
    // values read at the edge are those the edge sampled; the design updates later
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 0; penable_i <= 0;
  endtask
  task automatic conv(input logic [7:0] lt, input logic [13:0] rr);
    @(posedge sys_clk_i);
    conv_valid_i <= 1; local_temp_i <= lt; remote_raw_i <= rr;
    @(posedge sys_clk_i);
    conv_valid_i <= 0;
  endtask
  // only filter plus extension passes the two finest fraction bits
  function automatic logic [7:0] exp_lo(input logic [13:0] r, input logic [1:0] m);
    return {r[4:2], (m == 2'b11) ? r[1:0] : 2'b00, 3'b000};
  endfunction
  task automatic t_reset();
    apb(0, 12'h014, 8'h00); `CHK(q, 32'h0000_0046)
    `CHK(local_high_limit_o, 8'h46)
    apb(0, 12'h040, 8'h00); `CHK(q, 32'h0000_0000)
    $display("done: t_reset");
  endtask
  task automatic t_limit();
    apb(1, 12'h014, 8'hE2); apb(0, 12'h014, 8'h00); `CHK(q[7:0], 8'hE2)
    pstrb_i <= 4'h0; apb(1, 12'h014, 8'h11); pstrb_i <= 4'h1;
    apb(0, 12'h014, 8'h00); `CHK(local_high_limit_o, 8'hE2)
    $display("done: t_limit");
  endtask
  task automatic t_local();
    conv(8'h9C, 14'h0000); apb(0, 12'h000, 8'h00); `CHK(q, 32'h0000_009C)
    apb(1, 12'h000, 8'h05); `CHK(e, 1'b0)
    apb(1, 12'h004, 8'h05); apb(0, 12'h000, 8'h00); `CHK(q[7:0], 8'h9C)
    apb(0, 12'h004, 8'h00); `CHK(q[7:0], 8'h00)
    $display("done: t_local");
  endtask
  task automatic t_remote();
    for (int m = 0; m < 4; m++) begin
      apb(1, 12'h114, m[7:0]); apb(0, 12'h114, 8'h00); `CHK(q[1:0], m[1:0])
      `CHK({filter_en_o, extended_range_select_o}, m[1:0])
      foreach (raws[i]) begin
        conv(8'h00, raws[i]); apb(0, 12'h004, 8'h00); `CHK(q[7:0], raws[i][12:5])
        apb(0, 12'h040, 8'h00); `CHK(q[7:0], exp_lo(raws[i], m[1:0]))
      end
    end
    for (int m = 1; m >= 0; m--) begin
      apb(1, 12'h114, m[7:0]); conv(8'h00, 14'h0FFF); apb(0, 12'h004, 8'h00); `CHK(q[7:0], 8'h7F)
      apb(0, 12'h040, 8'h00); `CHK(q[7:0], m ? 8'hF8 : 8'hE0)
      apb(0, 12'h118, 8'h00); `CHK(q[1:0], 2'b11)
    end
    apb(0, 12'h118, 8'h00); `CHK(q[1:0], 2'b10)
    $display("done: t_remote");
  endtask
  task automatic t_shadow();
    apb(1, 12'h114, 8'h03); conv(8'h00, raws[0]); apb(0, 12'h004, 8'h00); conv(8'h00, raws[1]);
    apb(0, 12'h040, 8'h00); `CHK(q[7:0], exp_lo(raws[0], 2'b11))
    apb(0, 12'h004, 8'h00); apb(0, 12'h040, 8'h00); `CHK(q[7:0], exp_lo(raws[1], 2'b11))
    apb(0, 12'h008, 8'h00); `CHK({e, q}, {1'b1, 32'h0000_0000})
    apb(1, 12'h006, 8'h01); `CHK(e, 1'b1)
    $display("done: t_shadow");
  endtask
  task automatic wrap_up();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1;
    t_reset(); t_limit(); t_local(); t_remote(); t_shadow();
    wrap_up();
  end
endmodule
